// ===== hdl/lsc_defines.svh
// constants for the led, strap, reset and power-down control block
// included by the package and by every design module
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

`define LSC_CLK_HZ 20000000
`define LSC_RESET_MS 1
`define LSC_BLINK_ACT_HZ 10
`define LSC_BLINK_COL_HZ 20

`define LSC_ADDR_W 8
`define LSC_DATA_W 32
`define LSC_CNT_W 32

// register indices, byte address is four times the index
`define LSC_IDX_BCR 0
`define LSC_IDX_CCR 19
`define LSC_IDX_STRAP 20
`define LSC_IDX_STAT 21

`define LSC_BCR_LOOPBACK 14
`define LSC_BCR_SPEED 13
`define LSC_BCR_AUTONEG 12
`define LSC_BCR_PWRDN 11
`define LSC_BCR_DUPLEX 8
`define LSC_CCR_BYPASS 1
`define LSC_STRAP_LSB 3

`define LSC_STAT_RIP 0
`define LSC_STAT_PD 1
`define LSC_STAT_PD_PIN 2
`define LSC_STAT_ADV_LSB 3

`define LSC_BCR_SPEED_RST 1'b1
`define LSC_BCR_DUPLEX_RST 1'b0
`define LSC_BCR_AUTONEG_RST 1'b1

// led index order, strap bit = index + LSC_STRAP_LSB
`define LSC_LED_SPEED_HIGH 0
`define LSC_LED_DUPLEX_COL 1
`define LSC_LED_LINK 2
`define LSC_LED_ACTIVITY 3
`define LSC_LED_SPEED_LOW 4
`define LSC_LED_N 5

// input synchroniser bit order
`define LSC_SY_RST_N 0
`define LSC_SY_PWRDN 1
`define LSC_SY_CFG_A 2
`define LSC_SY_CFG_B 3
`define LSC_SY_AUTONEG 4
`define LSC_SY_LED_LSB 5
`define LSC_SY_N 10

`define LSC_RESP_OKAY 2'h0
`define LSC_RESP_SLVERR 2'h2

`endif

// ===== hdl/lsc_pkg.sv
// types shared by the led, strap, reset and power-down control block
// assumes lsc_defines.svh is on the include path
`include "lsc_defines.svh"

package lsc_pkg;

    typedef enum logic [1:0] {LSC_HOLD, LSC_WAIT, LSC_RUN} lsc_phase_type;

    typedef struct packed {
        logic awvalid;
        logic [`LSC_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [`LSC_DATA_W-1:0] wdata;
        logic [`LSC_DATA_W/8-1:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`LSC_ADDR_W-1:0] araddr;
        logic rready;
    } lsc_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [`LSC_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } lsc_axi_rsp_type;

    // line-side status from the datapath, same clock
    typedef struct packed {
        logic speed_10;
        logic speed_100;
        logic link_good;
        logic rx_act;
        logic tx_act;
        logic collision;
    } lsc_line_stat_type;

endpackage

// ===== hdl/lsc_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous levels; q is the second flop
`timescale 1ns/1ns
`include "lsc_defines.svh"

module lsc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lsc_sync_state_type;

    lsc_sync_state_type s_q;
    lsc_sync_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q <= {RST_VAL, RST_VAL};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;
endmodule

// ===== hdl/lsc_blink.sv
// square-wave blink source, phase toggles every HALF_CYCLES clocks
// assumes run is a same-clock level; counter restarts while run is low
`timescale 1ns/1ns
`include "lsc_defines.svh"

module lsc_blink #(
    parameter int unsigned HALF_CYCLES = 1000
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic run,
    output logic phase
);
    typedef struct packed {
        logic [`LSC_CNT_W-1:0] cnt;
        logic phase;
    } lsc_blink_state_type;

    lsc_blink_state_type s_q;
    lsc_blink_state_type s_d;

    always_comb begin
        s_d = s_q;
        if (!run) begin
            s_d.cnt = '0;
            s_d.phase = 1'b1;
        end else if (s_q.cnt == `LSC_CNT_W'(HALF_CYCLES - 1)) begin
            s_d.cnt = '0;
            s_d.phase = ~s_q.phase;
        end else begin
            s_d.cnt = s_q.cnt + `LSC_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign phase = s_q.phase;
endmodule

// ===== hdl/lsc_ctrl.sv
// led drivers, strap latch, reset sequencing and power-down control
// assumes AXI4-Lite master on clk_sys; pins are asynchronous, line status is same-clock
//
// Overview of operation
// - 10M led lit at 10M; strap bit 7
// - activity led blinks 10 Hz; strap bit 6
// - link led on, blinks on activity; bit 5
// - duplex led on full, 20 Hz collision; bit 4
// - 100M led lit at 100M; strap bit 3
// - autoneg on: both config pins pick advertisement
// - autoneg off: pin A sets MLT-3 bypass bit
// - autoneg off: pin B sets loopback bit 14
// - power-up reset always, lasts over 1 ms
// - ready output low until reset completes
// - power-down from pin OR control bit 11
// - power-down floats transmit, leds, isolates MII
// - control bit 8 selects full duplex
`timescale 1ns/1ns
`include "lsc_defines.svh"

module lsc_ctrl
    import lsc_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = (`LSC_RESET_MS * `LSC_CLK_HZ + 999) / 1000 + 1,
    parameter int unsigned ACT_HALF_CYCLES = `LSC_CLK_HZ / (2 * `LSC_BLINK_ACT_HZ),
    parameter int unsigned COL_HALF_CYCLES = `LSC_CLK_HZ / (2 * `LSC_BLINK_COL_HZ)
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire lsc_axi_req_type axi_req,
    output lsc_axi_rsp_type axi_rsp,
    input wire lsc_line_stat_type line_stat,
    input wire logic reset_pin_n,
    input wire logic power_down_pin,
    input wire logic config_pin_a,
    input wire logic config_pin_b,
    input wire logic autoneg_strap_pin,
    input wire logic [`LSC_LED_N-1:0] led_i,
    output logic [`LSC_LED_N-1:0] led_o,
    output logic [`LSC_LED_N-1:0] led_oe,
    output logic reset_done,
    output logic power_down,
    output logic tx_hiz,
    output logic mii_isolate,
    output logic loopback_en,
    output logic mlt3_bypass,
    output logic full_duplex,
    output logic speed_100_sel,
    output logic autoneg_en,
    output logic [1:0] adv_sel
);
    typedef struct packed {
        lsc_phase_type phase;
        logic [`LSC_CNT_W-1:0] rst_cnt;
        logic [`LSC_LED_N-1:0] strap;
        logic loopback;
        logic speed100;
        logic autoneg;
        logic pwrdn_bit;
        logic duplex;
        logic bypass;
        logic [1:0] adv;
        logic pd;
        logic rip;
        logic [`LSC_LED_N-1:0] led_o;
        logic [`LSC_LED_N-1:0] led_oe;
        lsc_axi_rsp_type rsp;
        logic aw_have;
        logic [`LSC_ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [`LSC_DATA_W-1:0] w_data;
        logic [`LSC_DATA_W/8-1:0] w_strb;
    } lsc_ctrl_state_type;

    localparam logic [`LSC_SY_N-1:0] SY_RST_VAL = `LSC_SY_N'(1) << `LSC_SY_RST_N;

    lsc_ctrl_state_type s_q;
    lsc_ctrl_state_type s_d;
    logic [`LSC_SY_N-1:0] pins_s;
    logic act_phase;
    logic col_phase;
    logic running;

    lsc_sync #(
        .W(`LSC_SY_N),
        .RST_VAL(SY_RST_VAL)
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .d({led_i, autoneg_strap_pin, config_pin_b, config_pin_a, power_down_pin, reset_pin_n}),
        .q(pins_s)
    );

    assign running = (s_q.phase == LSC_RUN);

    // blink counters restart whenever the device is not running
    lsc_blink #(
        .HALF_CYCLES(ACT_HALF_CYCLES)
    ) u_blink_act (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .run(running),
        .phase(act_phase)
    );

    lsc_blink #(
        .HALF_CYCLES(COL_HALF_CYCLES)
    ) u_blink_col (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .run(running),
        .phase(col_phase)
    );

    function automatic logic [15:0] merge16(
        input logic [15:0] cur,
        input logic [`LSC_DATA_W-1:0] wd,
        input logic [`LSC_DATA_W/8-1:0] st
    );
        logic [15:0] r;
        r = cur;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    function automatic logic [15:0] bcr_word(input lsc_ctrl_state_type s);
        logic [15:0] r;
        r = '0;
        r[`LSC_BCR_LOOPBACK] = s.loopback;
        r[`LSC_BCR_SPEED] = s.speed100;
        r[`LSC_BCR_AUTONEG] = s.autoneg;
        r[`LSC_BCR_PWRDN] = s.pwrdn_bit;
        r[`LSC_BCR_DUPLEX] = s.duplex;
        return r;
    endfunction

    function automatic logic [15:0] ccr_word(input lsc_ctrl_state_type s);
        logic [15:0] r;
        r = '0;
        r[`LSC_CCR_BYPASS] = s.bypass;
        return r;
    endfunction

    always_comb begin
        logic [`LSC_ADDR_W-3:0] idx;
        logic [15:0] nw;
        logic [`LSC_LED_N-1:0] lit;
        logic line_act;
        idx = '0;
        nw = '0;
        lit = '0;
        line_act = line_stat.rx_act | line_stat.tx_act;
        s_d = s_q;

        // read channel: data registered at the address handshake
        if (s_q.rsp.rvalid && axi_req.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (s_q.rsp.arready && axi_req.arvalid) begin
            idx = axi_req.araddr[`LSC_ADDR_W-1:2];
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rresp = `LSC_RESP_OKAY;
            s_d.rsp.rdata = '0;
            case (idx)
                `LSC_IDX_BCR: begin
                    s_d.rsp.rdata[15:0] = bcr_word(s_q);
                end
                `LSC_IDX_CCR: begin
                    s_d.rsp.rdata[15:0] = ccr_word(s_q);
                end
                `LSC_IDX_STRAP: begin
                    s_d.rsp.rdata[`LSC_STRAP_LSB +: `LSC_LED_N] = s_q.strap;
                end
                `LSC_IDX_STAT: begin
                    s_d.rsp.rdata[`LSC_STAT_RIP] = s_q.rip;
                    s_d.rsp.rdata[`LSC_STAT_PD] = s_q.pd;
                    s_d.rsp.rdata[`LSC_STAT_PD_PIN] = pins_s[`LSC_SY_PWRDN];
                    s_d.rsp.rdata[`LSC_STAT_ADV_LSB +: 2] = s_q.adv;
                end
                default: begin
                    s_d.rsp.rresp = `LSC_RESP_SLVERR;
                end
            endcase
        end
        s_d.rsp.arready = !s_d.rsp.rvalid;

        // write channel: address and data taken in either order
        if (s_q.rsp.bvalid && axi_req.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        if (s_q.rsp.awready && axi_req.awvalid) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (s_q.rsp.wready && axi_req.wvalid) begin
            s_d.w_have = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = `LSC_RESP_OKAY;
            idx = s_q.aw_addr[`LSC_ADDR_W-1:2];
            if (!running) begin
                // registers are not writable until reset completes
                s_d.rsp.bresp = `LSC_RESP_SLVERR;
            end else begin
                case (idx)
                    `LSC_IDX_BCR: begin
                        nw = merge16(bcr_word(s_q), s_q.w_data, s_q.w_strb);
                        s_d.loopback = nw[`LSC_BCR_LOOPBACK];
                        s_d.speed100 = nw[`LSC_BCR_SPEED];
                        s_d.autoneg = nw[`LSC_BCR_AUTONEG];
                        s_d.pwrdn_bit = nw[`LSC_BCR_PWRDN];
                        s_d.duplex = nw[`LSC_BCR_DUPLEX];
                    end
                    `LSC_IDX_CCR: begin
                        nw = merge16(ccr_word(s_q), s_q.w_data, s_q.w_strb);
                        s_d.bypass = nw[`LSC_CCR_BYPASS];
                    end
                    // read-only registers accept the write and keep their value
                    `LSC_IDX_STRAP, `LSC_IDX_STAT: begin
                        s_d.rsp.bresp = `LSC_RESP_OKAY;
                    end
                    default: begin
                        s_d.rsp.bresp = `LSC_RESP_SLVERR;
                    end
                endcase
            end
        end
        s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
        s_d.rsp.wready = !s_d.w_have && !s_d.rsp.bvalid;

        // reset sequencing; leds float so the straps can be sampled
        case (s_q.phase)
            LSC_HOLD: begin
                s_d.rst_cnt = '0;
                if (pins_s[`LSC_SY_RST_N]) begin
                    s_d.phase = LSC_WAIT;
                end
            end
            LSC_WAIT: begin
                s_d.rst_cnt = s_q.rst_cnt + `LSC_CNT_W'(1);
                if (s_q.rst_cnt == `LSC_CNT_W'(RESET_CYCLES - 1)) begin
                    s_d.phase = LSC_RUN;
                    s_d.rip = 1'b1;
                    s_d.strap = pins_s[`LSC_SY_LED_LSB +: `LSC_LED_N];
                    s_d.autoneg = pins_s[`LSC_SY_AUTONEG];
                    if (pins_s[`LSC_SY_AUTONEG]) begin
                        s_d.adv = {pins_s[`LSC_SY_CFG_B], pins_s[`LSC_SY_CFG_A]};
                        s_d.bypass = 1'b0;
                        s_d.loopback = 1'b0;
                    end else begin
                        s_d.adv = 2'h0;
                        s_d.bypass = pins_s[`LSC_SY_CFG_A];
                        s_d.loopback = pins_s[`LSC_SY_CFG_B];
                    end
                end
            end
            LSC_RUN: begin
                s_d.rst_cnt = '0;
            end
            default: begin
                s_d.phase = LSC_HOLD;
            end
        endcase

        // a low reset pin restarts the whole sequence and returns control to its reset values
        if (!pins_s[`LSC_SY_RST_N]) begin
            s_d.phase = LSC_HOLD;
            s_d.rst_cnt = '0;
            s_d.rip = 1'b0;
            s_d.loopback = 1'b0;
            s_d.speed100 = `LSC_BCR_SPEED_RST;
            s_d.autoneg = `LSC_BCR_AUTONEG_RST;
            s_d.pwrdn_bit = 1'b0;
            s_d.duplex = `LSC_BCR_DUPLEX_RST;
            s_d.bypass = 1'b0;
            s_d.adv = 2'h0;
        end

        s_d.pd = pins_s[`LSC_SY_PWRDN] | s_d.pwrdn_bit;

        // lit state of each led
        lit[`LSC_LED_SPEED_LOW] = line_stat.speed_10;
        lit[`LSC_LED_ACTIVITY] = line_act & act_phase;
        lit[`LSC_LED_LINK] = line_act ? act_phase : line_stat.link_good;
        lit[`LSC_LED_DUPLEX_COL] = s_q.duplex | (line_stat.collision & col_phase);
        lit[`LSC_LED_SPEED_HIGH] = line_stat.speed_100;

        if ((s_d.phase == LSC_RUN) && !s_d.pd) begin
            s_d.led_oe = '1;
            s_d.led_o = s_d.strap ^ lit;
        end else begin
            s_d.led_oe = '0;
            s_d.led_o = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // power-up reset runs whatever the reset pin shows
            s_q <= '0;
            s_q.phase <= LSC_WAIT;
            s_q.speed100 <= `LSC_BCR_SPEED_RST;
            s_q.autoneg <= `LSC_BCR_AUTONEG_RST;
            s_q.duplex <= `LSC_BCR_DUPLEX_RST;
            s_q.rsp.awready <= 1'b1;
            s_q.rsp.wready <= 1'b1;
            s_q.rsp.arready <= 1'b1;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign axi_rsp = s_q.rsp;
    assign led_o = s_q.led_o;
    assign led_oe = s_q.led_oe;
    assign reset_done = s_q.rip;
    assign power_down = s_q.pd;
    assign tx_hiz = s_q.pd;
    assign mii_isolate = s_q.pd;
    assign loopback_en = s_q.loopback;
    assign mlt3_bypass = s_q.bypass;
    assign full_duplex = s_q.duplex;
    assign speed_100_sel = s_q.speed100;
    assign autoneg_en = s_q.autoneg;
    assign adv_sel = s_q.adv;
endmodule

// ===== test/lsc_ctrl_properties.sv
// port checker for lsc_ctrl
// assumes ce held high and the board model on the led pins
`timescale 1ns/1ns
`include "lsc_defines.svh"
module lsc_ctrl_properties
    import lsc_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire lsc_axi_req_type axi_req,
    input wire lsc_axi_rsp_type axi_rsp,
    input wire lsc_line_stat_type line_stat,
    input wire logic reset_pin_n,
    input wire logic power_down_pin,
    input wire logic [`LSC_LED_N-1:0] led_i,
    input wire logic [`LSC_LED_N-1:0] led_o,
    input wire logic [`LSC_LED_N-1:0] led_oe,
    input wire logic reset_done,
    input wire logic power_down,
    input wire logic tx_hiz,
    input wire logic mii_isolate,
    input wire logic full_duplex
);
    logic [15:0] hi_q;
    logic [`LSC_LED_N-1:0] strap_q;
    logic line_act;
    assign line_act = line_stat.rx_act | line_stat.tx_act;
    // cycles since reset pin and system reset were last released
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !reset_pin_n) hi_q <= 16'h0000;
        else if (hi_q != 16'hFFFF) hi_q <= hi_q + 16'h0001;
        for (int i = 0; i < `LSC_LED_N; i++) begin
            if (!led_oe[i]) strap_q[i] <= led_i[i];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence pin_low3;
        !reset_pin_n [*3];
    endsequence
    sequence pd_pin3;
        power_down_pin [*3];
    endsequence
    property p_steady(int i, logic lit);
        led_oe[i] && $past(led_oe[i]) |-> led_o[i] == (strap_q[i] ^ $past(lit));
    endproperty
    chk_rip_hold: assert property (pin_low3 |=> !reset_done)
        else $error("ready while reset pin low");
    chk_rip_early: assert property ($rose(reset_done) |-> hi_q >= RESET_CYCLES - 1)
        else $error("ready too early");
    chk_rip_late: assert property (hi_q == RESET_CYCLES + 5 |-> reset_done)
        else $error("ready too late");
    chk_pd_pin: assert property (pd_pin3 |=> power_down)
        else $error("power-down pin ignored");
    chk_pd_float: assert property (power_down |-> led_oe == 5'h00 && tx_hiz && mii_isolate)
        else $error("outputs driven in power-down");
    chk_pd_clear: assert property (!power_down |-> !tx_hiz && !mii_isolate && led_oe == {`LSC_LED_N{reset_done}})
        else $error("isolated while powered");
    chk_led_slow: assert property (p_steady(4, line_stat.speed_10))
        else $error("10M led wrong");
    chk_led_fast: assert property (p_steady(0, line_stat.speed_100))
        else $error("100M led wrong");
    chk_led_link: assert property (led_oe[2] && $past(led_oe[2]) && !$past(line_act)
        |-> led_o[2] == (strap_q[2] ^ $past(line_stat.link_good)))
        else $error("link led wrong");
    chk_led_idle: assert property (led_oe[3] && $past(led_oe[3]) && !$past(line_act)
        |-> led_o[3] == strap_q[3])
        else $error("activity led lit when idle");
    chk_led_fdx: assert property (led_oe[1] && $past(led_oe[1]) && $past(full_duplex) && full_duplex
        |-> led_o[1] == !strap_q[1])
        else $error("duplex led not lit");
    chk_rd_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read not answered");
    chk_b_stand: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write response dropped");
endmodule

bind lsc_ctrl lsc_ctrl_properties #(.RESET_CYCLES(RESET_CYCLES)) lsc_ctrl_properties_inst (.clk_sys, .sys_rst,
    .axi_req, .axi_rsp, .line_stat, .reset_pin_n, .power_down_pin, .led_i, .led_o, .led_oe, .reset_done,
    .power_down, .tx_hiz, .mii_isolate, .full_duplex);

// ===== test/lsc_board.sv
// board model: strap resistors on the led pins and a reset button
// assumes the block's led drive and enable outputs
`timescale 1ns/1ns
`include "lsc_defines.svh"
module lsc_board #(
    parameter logic [`LSC_LED_N-1:0] STRAP = 5'h16
) (
    input wire logic clk_sys,
    input wire logic [`LSC_LED_N-1:0] led_o,
    input wire logic [`LSC_LED_N-1:0] led_oe,
    output logic [`LSC_LED_N-1:0] led_i,
    output logic reset_pin_n
);
    // an undriven pin sits at its pull resistor level
    always_comb begin
        for (int i = 0; i < `LSC_LED_N; i++) led_i[i] = led_oe[i] ? led_o[i] : STRAP[i];
    end
    initial reset_pin_n = 1'b1;
    task automatic push_reset(input int cycles);
        begin
            @(posedge clk_sys);
            reset_pin_n <= 1'b0;
            repeat (cycles) @(posedge clk_sys);
            reset_pin_n <= 1'b1;
        end
    endtask
endmodule

// ===== test/lsc_ctrl_test.sv
// self-checking bench for lsc_ctrl
// assumes lsc_board on the pins and the bound port checker
`timescale 1ns/1ns
`include "lsc_defines.svh"
module lsc_ctrl_test
    import lsc_pkg::*;
;
    localparam int unsigned RC = 20;
    localparam logic [4:0] STRAP = 5'h16;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    lsc_axi_req_type req = '0;
    lsc_axi_rsp_type rsp;
    lsc_line_stat_type ls = '0;
    logic pd_pin = 1'b0;
    logic cfg_a = 1'b0;
    logic cfg_b = 1'b0;
    logic an_pin = 1'b1;
    logic [4:0] led_i, led_o, led_oe;
    logic reset_pin_n, reset_done, power_down, tx_hiz, mii_isolate, loopback_en, mlt3_bypass;
    logic full_duplex, autoneg_en, speed_100_sel;
    logic [1:0] adv_sel, resp;
    logic [31:0] rd;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    lsc_ctrl #(.RESET_CYCLES(RC), .ACT_HALF_CYCLES(4), .COL_HALF_CYCLES(2)) lsc_ctrl_inst (.clk_sys, .sys_rst,
        .ce(1'b1), .axi_req(req), .axi_rsp(rsp), .line_stat(ls), .reset_pin_n, .power_down_pin(pd_pin),
        .config_pin_a(cfg_a), .config_pin_b(cfg_b), .autoneg_strap_pin(an_pin), .led_i, .led_o, .led_oe,
        .reset_done, .power_down, .tx_hiz, .mii_isolate, .loopback_en, .mlt3_bypass, .full_duplex,
        .speed_100_sel, .autoneg_en, .adv_sel);
    lsc_board #(.STRAP(STRAP)) lsc_board_inst (.clk_sys, .led_o, .led_oe, .led_i, .reset_pin_n);
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 4000) begin
            err_total++;
            $display("MISMATCH %0t timeout", $time);
            stop_test();
        end
    end
    task automatic stop_test;
        begin
            $display("checked %0d mismatches %0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        begin
            samples_checked++;
            if (got !== exp) begin
                err_total++;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        begin
            chk_val({31'h0, got}, {31'h0, exp});
        end
    endtask
    task automatic tick(input int n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge clk_sys);
            req.awvalid <= 1'b1;
            req.awaddr <= a;
            req.wvalid <= 1'b1;
            req.wdata <= d;
            req.wstrb <= 4'hF;
            req.bready <= 1'b1;
            resp = 2'h3;
            while (resp === 2'h3) begin
                @(posedge clk_sys);
                if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
                if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
                if (rsp.bvalid) begin
                    resp = rsp.bresp;
                    req.bready <= 1'b0;
                end
            end
        end
    endtask
    task automatic axr(input logic [7:0] a);
        begin
            @(posedge clk_sys);
            req.arvalid <= 1'b1;
            req.araddr <= a;
            req.rready <= 1'b1;
            resp = 2'h3;
            while (resp === 2'h3) begin
                @(posedge clk_sys);
                if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
                if (rsp.rvalid) begin
                    resp = rsp.rresp;
                    rd = rsp.rdata;
                    req.rready <= 1'b0;
                end
            end
        end
    endtask
    task automatic wait_ready;
        begin
            while (reset_done !== 1'b1) tick(1);
        end
    endtask
    task automatic t_powerup;
        int t0;
        begin
            t0 = cycles;
            axw(8'h00, 32'h0000_0100);
            chk_val(resp, `LSC_RESP_SLVERR);
            chk_bit(full_duplex, 1'b0);
            axr(8'h10);
            chk_val(resp, `LSC_RESP_SLVERR);
            wait_ready();
            chk_bit(cycles - t0 >= RC - 1 && cycles - t0 <= RC + 3, 1'b1);
            axr(8'h50);
            chk_val(rd, {24'h0, STRAP, 3'h0});
            axr(8'h54);
            chk_bit(rd[0], 1'b1);
            $display("test powerup done");
        end
    endtask
    task automatic t_config(input logic an, input logic a, input logic b);
        begin
            @(posedge clk_sys);
            an_pin <= an;
            cfg_a <= a;
            cfg_b <= b;
            lsc_board_inst.push_reset(RC);
            tick(3);
            chk_bit(reset_done, 1'b0);
            wait_ready();
            chk_bit(mlt3_bypass, !an && a);
            chk_bit(loopback_en, !an && b);
            chk_val(32'(adv_sel), an ? {30'h0, b, a} : 32'h0);
            axr(8'h4C);
            chk_bit(rd[1], !an && a);
            axr(8'h00);
            chk_bit(rd[14], !an && b);
            chk_bit(autoneg_en, an);
            $display("test config done");
        end
    endtask
    task automatic count_flips(input int idx, input int exp);
        int f;
        logic last;
        begin
            tick(1);
            last = led_o[idx];
            f = 0;
            repeat (16) begin
                tick(1);
                if (led_o[idx] !== last) f++;
                last = led_o[idx];
            end
            chk_val(32'(f), 32'(exp));
        end
    endtask
    task automatic t_leds;
        begin
            @(posedge clk_sys);
            ls <= 6'h28; // speed_10 with good link
            tick(3);
            chk_bit(led_o[4], !STRAP[4]);
            chk_bit(led_o[0], STRAP[0]);
            chk_bit(led_o[2], !STRAP[2]);
            chk_bit(led_o[3], STRAP[3]);
            @(posedge clk_sys);
            ls <= 6'h14; // speed_100 with receive activity
            tick(3);
            chk_bit(led_o[0], !STRAP[0]);
            chk_bit(led_o[4], STRAP[4]);
            count_flips(3, 4);
            count_flips(2, 4);
            @(posedge clk_sys);
            ls <= 6'h01; // collision in half duplex
            tick(2);
            count_flips(1, 8);
            axw(8'h00, 32'h0000_1100);
            tick(2);
            chk_bit(full_duplex, 1'b1);
            chk_bit(speed_100_sel, 1'b0);
            count_flips(1, 0);
            chk_bit(led_o[1], !STRAP[1]);
            $display("test leds done");
        end
    endtask
    task automatic t_power;
        begin
            @(posedge clk_sys);
            pd_pin <= 1'b1;
            tick(4);
            chk_bit(power_down, 1'b1);
            chk_bit(tx_hiz && mii_isolate, 1'b1);
            chk_val(32'(led_oe), 32'h0);
            @(posedge clk_sys);
            pd_pin <= 1'b0;
            tick(4);
            chk_bit(power_down, 1'b0);
            chk_val(32'(led_oe), 32'h1F);
            axw(8'h00, 32'h0000_1900);
            tick(1);
            chk_bit(power_down, 1'b1);
            chk_val(32'(led_oe), 32'h0);
            axw(8'h00, 32'h0000_1100);
            tick(1);
            chk_bit(power_down, 1'b0);
            $display("test power done");
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_powerup();
        t_config(1'b0, 1'b1, 1'b1);
        t_config(1'b0, 1'b0, 1'b0);
        t_config(1'b1, 1'b0, 1'b1);
        t_config(1'b1, 1'b1, 1'b0);
        t_leds();
        t_power();
        stop_test();
    end
endmodule
